/* File: core/cbsw_crossbar.v */
// Five-master, five-target crossbar switch with fixed-priority arbiters,
// per-target bridge stages and an APB slave for the bridge control bit.
// Assumes masters hold a request until they see done, and targets hold
// ack high for one edge once the forwarded access is finished.
//
// Implementation choice: the APB slave port.
`include "cbsw_regs.vh"

module cbsw_crossbar (
    input  wire         clk_i,        // System clock
    input  wire         rst_b_i,      // Async reset, active low
    input  wire [4:0]   mst_req_i,    // Per-master request level
    input  wire [4:0]   mst_we_i,     // Per-master write flag
    input  wire [159:0] mst_addr_i,   // Per-master byte address
    input  wire [159:0] mst_wdata_i,  // Per-master write data
    output reg  [4:0]   mst_done_o,   // Per-master completion pulse
    output reg  [4:0]   mst_err_o,    // Per-master error with done
    output reg  [159:0] mst_rdata_o,  // Per-master read data
    output reg  [4:0]   tgt_req_o,    // Per-target request level
    output reg  [4:0]   tgt_we_o,     // Per-target write flag
    output reg  [159:0] tgt_addr_o,   // Per-target address
    output reg  [159:0] tgt_wdata_o,  // Per-target write data
    input  wire [4:0]   tgt_ack_i,    // Per-target completion
    input  wire [159:0] tgt_rdata_i,  // Per-target read data
    input  wire [31:0]  paddr_i,      // APB address
    input  wire         psel_i,       // APB select
    input  wire         penable_i,    // APB enable
    input  wire         pwrite_i,     // APB write
    input  wire [31:0]  pwdata_i,     // APB write data
    output reg  [31:0]  prdata_o,     // APB read data
    output reg          pready_o,     // APB ready
    output reg          pslverr_o,    // APB error on unmapped address
    output reg          mem_bridge_reset_o // On-chip bridge held in reset
);

    reg [4:0]  tgt_busy;
    reg [4:0]  mst_busy;
    reg [2:0]  owner [0:4];
    reg        memory_bridge_reset;
    wire [2:0] dec [0:4];
    wire [4:0] legal;
    wire [24:0] cand;
    wire [24:0] hit;
    wire [2:0] win [0:4];
    reg  [31:0] next_prdata;
    integer    i;

    // Address map to target group
    function [2:0] cbsw_decode;
        input [31:0] a;
        begin
            if (a[31:28] == 4'h0 || a[31:28] == 4'h1)
                cbsw_decode = `CBSW_T_ONCHIP;
            else if (a[31:28] == 4'h8 || a[31:28] == 4'h9)
                cbsw_decode = `CBSW_T_EXTMEM;
            else if (a[31:24] >= 8'h40 && a[31:24] <= 8'h4a)
                cbsw_decode = `CBSW_T_PERIPH;
            else if (a[31:24] >= 8'h54 && a[31:24] <= 8'h56)
                cbsw_decode = `CBSW_T_AUDIO;
            else if (a[31:24] >= 8'h60 && a[31:24] <= 8'h62)
                cbsw_decode = `CBSW_T_DMAREG;
            else
                cbsw_decode = `CBSW_T_NONE;
        end
    endfunction

    // Targets each master may reach
    function [4:0] cbsw_mask;
        input integer m;
        begin
            if (m == `CBSW_M_CPU)
                cbsw_mask = `CBSW_MASK_CPU;
            else if (m == `CBSW_M_FILL)
                cbsw_mask = `CBSW_MASK_FILL;
            else
                cbsw_mask = `CBSW_MASK_OTHER;
        end
    endfunction

    // Fixed-priority pick; fill drops to last place at external memory
    function [2:0] cbsw_pick;
        input [4:0] c;
        input       ext;
        begin
            if (c[0])
                cbsw_pick = `CBSW_M_CPU;
            else if (c[1] && !ext)
                cbsw_pick = `CBSW_M_FILL;
            else if (c[2])
                cbsw_pick = `CBSW_M_HIDMA;
            else if (c[3])
                cbsw_pick = `CBSW_M_LODMA;
            else if (c[4])
                cbsw_pick = `CBSW_M_HOST;
            else
                cbsw_pick = `CBSW_M_FILL;
        end
    endfunction

    genvar g;
    genvar h;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_mst
            // One-hot target of each master; unmapped shifts out to zero
            wire [4:0] reach;
            assign reach = cbsw_mask(g);
            assign dec[g] = cbsw_decode(mst_addr_i[32*g +: 32]);
            assign hit[5*g +: 5] = 5'h01 << dec[g];
            assign legal[g] = |(reach & hit[5*g +: 5]);
        end
        for (h = 0; h < 5; h = h + 1) begin : g_tgt
            for (g = 0; g < 5; g = g + 1) begin : g_cand
                // Done masters are skipped so a finished request is not
                // granted again in the edge where the master drops it
                assign cand[5*h + g] = mst_req_i[g] && legal[g] &&
                    hit[5*g + h] && !mst_busy[g] &&
                    !mst_done_o[g] &&
                    !(h == 0 && memory_bridge_reset);
            end
            assign win[h] = cbsw_pick(cand[5*h +: 5], h == 1);
        end
    endgenerate

    // Arbitration, bridge stages and completion
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tgt_busy    <= 5'h00;
            mst_busy    <= 5'h00;
            mst_done_o  <= 5'h00;
            mst_err_o   <= 5'h00;
            mst_rdata_o <= 160'h0;
            tgt_req_o   <= 5'h00;
            tgt_we_o    <= 5'h00;
            tgt_addr_o  <= 160'h0;
            tgt_wdata_o <= 160'h0;
            for (i = 0; i < 5; i = i + 1)
                owner[i] <= 3'h0;
        end else begin
            mst_done_o <= 5'h00;
            mst_err_o  <= 5'h00;
            // Unreachable target or unmapped address ends at once in error
            for (i = 0; i < 5; i = i + 1) begin
                if (mst_req_i[i] && !legal[i] && !mst_done_o[i]) begin
                    mst_done_o[i] <= 1'b1;
                    mst_err_o[i]  <= 1'b1;
                end
            end
            // Each target runs its own arbiter, so paths never block
            for (i = 0; i < 5; i = i + 1) begin
                if (tgt_busy[i]) begin
                    if (tgt_ack_i[i]) begin
                        tgt_busy[i]            <= 1'b0;
                        tgt_req_o[i]           <= 1'b0;
                        mst_busy[owner[i]]     <= 1'b0;
                        mst_done_o[owner[i]]   <= 1'b1;
                        mst_rdata_o[32*owner[i] +: 32] <=
                            tgt_rdata_i[32*i +: 32];
                    end else if (i == 0 && memory_bridge_reset) begin
                        // Bridge reset flushes its pending access
                        tgt_busy[i]            <= 1'b0;
                        tgt_req_o[i]           <= 1'b0;
                        mst_busy[owner[i]]     <= 1'b0;
                        mst_done_o[owner[i]]   <= 1'b1;
                        mst_err_o[owner[i]]    <= 1'b1;
                    end
                end else if (|cand[5*i +: 5]) begin
                    // Bridge stage: one-entry buffer per target path
                    owner[i]               <= win[i];
                    tgt_busy[i]            <= 1'b1;
                    mst_busy[win[i]]       <= 1'b1;
                    tgt_req_o[i]           <= 1'b1;
                    tgt_we_o[i]            <= mst_we_i[win[i]];
                    tgt_addr_o[32*i +: 32] <=
                        mst_addr_i[32*win[i] +: 32];
                    tgt_wdata_o[32*i +: 32] <=
                        mst_wdata_i[32*win[i] +: 32];
                end
            end
        end
    end

    // APB read mux; reserved bits read as zero
    always @* begin
        next_prdata = 32'h0;
        if (paddr_i == `CBSW_ADDR_BRIDGE_CTRL)
            next_prdata[`CBSW_BRIDGE_RST_BIT] = memory_bridge_reset;
        else if (paddr_i == `CBSW_ADDR_STATUS) begin
            next_prdata[`CBSW_STAT_BUSY_LSB +: 5] = tgt_busy;
            next_prdata[`CBSW_STAT_BRRST_BIT]     = memory_bridge_reset;
        end
    end

    // APB slave: ready in the first access cycle
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            memory_bridge_reset <= `CBSW_BRIDGE_RST_RESET;
            mem_bridge_reset_o  <= `CBSW_BRIDGE_RST_RESET;
            prdata_o            <= 32'h0;
            pready_o            <= 1'b0;
            pslverr_o           <= 1'b0;
        end else begin
            pready_o           <= psel_i && !penable_i;
            mem_bridge_reset_o <= memory_bridge_reset;
            if (psel_i && !penable_i) begin
                prdata_o  <= next_prdata;
                pslverr_o <= (paddr_i != `CBSW_ADDR_BRIDGE_CTRL) &&
                             (paddr_i != `CBSW_ADDR_STATUS);
            end
            if (psel_i && penable_i && pready_o && pwrite_i &&
                paddr_i == `CBSW_ADDR_BRIDGE_CTRL)
                memory_bridge_reset <= pwdata_i[`CBSW_BRIDGE_RST_BIT];
        end
    end

endmodule

/* File: core/cbsw_regs.vh */
// Constants for the crossbar bus switch: register map, address decode,
// route masks and master numbering.
// Assumes one clock for all ports; the includer uses the names only.
//
// Behaviour
// - Requests come from five masters: CPU data, program fill, two DMA, host.
// - CPU data reaches peripherals, DMA registers, external memory; fill only external.
// - Five targets: on-chip memory, external memory, peripherals, audio bus, DMA regs.
// - Different masters to different targets proceed together without stalling.
// - Same-cycle contention for one target grants the best master, stalls others.
// - An owner keeps its target until its access completes.
// - High-priority DMA beats low-priority DMA on a shared target.
// - Program fill has lowest priority at the external memory target.
// - Program fill reaches external memory through a single bridge stage.
// - Each cross-domain path holds its access in a small bridge buffer.
// - CPU data bridge passes first-clock requests to second-clock targets.
// - DMA and host bridge to on-chip memory passes second to first clock.
// - Program fill bridge passes first to third clock.
// - Shared external bridge passes second to third clock.
// - Control bit 0 holds the on-chip memory bridge in reset; resets to 1.
// - Upper control bits read undefined; software writes only zeros there.
`ifndef CBSW_REGS_VH
`define CBSW_REGS_VH

`define CBSW_ADDR_BRIDGE_CTRL   32'h40000024
`define CBSW_ADDR_STATUS        32'h40000028
`define CBSW_BRIDGE_RST_BIT     0
`define CBSW_BRIDGE_RST_RESET   1'h1
`define CBSW_STAT_BUSY_LSB      0
`define CBSW_STAT_BRRST_BIT     5

`define CBSW_M_CPU              3'h0
`define CBSW_M_FILL             3'h1
`define CBSW_M_HIDMA            3'h2
`define CBSW_M_LODMA            3'h3
`define CBSW_M_HOST             3'h4

`define CBSW_T_ONCHIP           3'h0
`define CBSW_T_EXTMEM           3'h1
`define CBSW_T_PERIPH           3'h2
`define CBSW_T_AUDIO            3'h3
`define CBSW_T_DMAREG           3'h4
`define CBSW_T_NONE             3'h7

`define CBSW_MASK_CPU           5'h16
`define CBSW_MASK_FILL          5'h02
`define CBSW_MASK_OTHER         5'h1f

`endif

/* File: verif/cbsw_crossbar_props.sv */
// Port assertions for the crossbar switch.
// Assumes one clock and an active-low async reset.
module cbsw_crossbar_props (
    input logic         clk_i,      // Clock
    input logic         rst_b_i,    // Reset
    input logic [4:0]   mst_req_i,  // Requests
    input logic [159:0] mst_addr_i, // Addresses
    input logic [4:0]   mst_done_o, // Done
    input logic [4:0]   mst_err_o,  // Error
    input logic [4:0]   tgt_req_o,  // Target req
    input logic [159:0] tgt_addr_o, // Target addr
    input logic [4:0]   tgt_ack_i,  // Target ack
    input logic [31:0]  paddr_i,    // APB addr
    input logic         psel_i,     // APB select
    input logic         penable_i,  // APB enable
    input logic         pready_o,   // APB ready
    input logic         pslverr_o,  // APB error
    input logic         mem_bridge_reset_o // Bridge reset
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    function automatic logic ph(logic [31:0] a);
        return a[31:24] >= 8'h40 && a[31:24] <= 8'h4a;
    endfunction
    a_done_pulse: assert property (mst_done_o != 5'h0 |=>
        (mst_done_o & $past(mst_done_o)) == 5'h0) else $error("done held");
    a_fill_ext_only: assert property ($rose(mst_req_i[1]) &&
        !(mst_addr_i[63:60] inside {4'h8, 4'h9}) |=> mst_err_o[1] &&
        mst_done_o[1]) else $error("fill route not refused");
    a_onchip_gated: assert property ($rose(tgt_req_o[0]) |->
        !mem_bridge_reset_o) else $error("onchip granted in reset");
    a_apb_no_wait: assert property (psel_i && !penable_i |=>
        pready_o ##1 !pready_o) else $error("pready timing");
    a_apb_unmapped: assert property (psel_i && !penable_i &&
        !(paddr_i inside {32'h40000024, 32'h40000028}) |=> pslverr_o)
        else $error("unmapped not refused");
    a_ack_done: assert property (tgt_req_o[2] && tgt_ack_i[2]
        |=> mst_done_o != 5'h0) else $error("no done after ack");
    a_ext_hold: assert property (tgt_req_o[1] && !tgt_ack_i[1]
        |=> tgt_req_o[1] && $stable(tgt_addr_o[63:32]))
        else $error("ext request dropped");
    a_hi_first: assert property (!mst_req_i[0] && !tgt_req_o[2] &&
        $rose(mst_req_i[2]) && $rose(mst_req_i[3]) && ph(mst_addr_i[95:64])
        && ph(mst_addr_i[127:96]) |=> tgt_req_o[2] &&
        tgt_addr_o[95:64] == $past(mst_addr_i[95:64])) else $error("lo won");
    c_onchip: cover property (tgt_req_o[0]);
    c_two_tgt: cover property (tgt_req_o[2] && tgt_req_o[3]);
    c_err: cover property (mst_err_o != 5'h0);
endmodule

/* File: verif/cbsw_tgt_model.sv */
// Target model: each target acks a held request once, maybe late.
// Assumes requests stay high until the ack edge.
module cbsw_tgt_model (
    input  logic         clk_i,  // Clock
    input  logic         slow_i, // Random ack delay
    input  logic [4:0]   req_i,  // Target requests
    input  logic [159:0] addr_i, // Target addresses
    output logic [4:0]   ack_o,  // Ack pulses
    output logic [159:0] rdata_o // Read data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial ack_o = 5'h0;
    always @(posedge clk_i) begin
        for (int t = 0; t < 5; t++) begin
            if (req_i[t] && !ack_o[t] && (!slow_i || $urandom_range(1))) begin
                ack_o[t] <= 1'h1;
                rdata_o[32*t+:32] <= ~addr_i[32*t+:32];
            end else begin
                // Idle lanes carry noise so stale data never matches
                ack_o[t] <= 1'h0;
                rdata_o[32*t+:32] <= $urandom;
            end
        end
    end
endmodule

/* File: verif/cbsw_crossbar_tb.sv */
// Bench for the crossbar switch: APB, five masters, target model.
// Assumes the register header on the include path.
`include "cbsw_regs.vh"
module cbsw_crossbar_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk_i, rst_b_i, psel, pen, pwr, prdy, perr, brst, slow, er;
    logic [4:0]   req, we, done, err, treq, tack, twe;
    logic [159:0] addr, wdata, rdata, taddr, trdata, twdata;
    logic [31:0]  paddr, pwdata, prdata, rd, ea [5], ewd [5];
    logic [7:0]   base [5] = '{8'h10, 8'h80, 8'h40, 8'h54, 8'h60};
    logic         ew [5];
    int           n_mismatch, checks_done, cyc, m, fin [5], et [5];
    cbsw_crossbar dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .mst_req_i(req),
        .mst_we_i(we), .mst_addr_i(addr), .mst_wdata_i(wdata),
        .mst_done_o(done), .mst_err_o(err), .mst_rdata_o(rdata),
        .tgt_req_o(treq), .tgt_we_o(twe), .tgt_addr_o(taddr),
        .tgt_wdata_o(twdata),
        .tgt_ack_i(tack), .tgt_rdata_i(trdata), .paddr_i(paddr),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr),
        .mem_bridge_reset_o(brst));
    cbsw_tgt_model tgt (.clk_i(clk_i), .slow_i(slow), .req_i(treq),
        .addr_i(taddr), .ack_o(tack), .rdata_o(trdata));
    function automatic logic ok(int m, int t);
        return m == 0 ? t inside {1, 2, 4} : (m != 1 || t == 1);
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(logic [31:0] a, logic w, logic [31:0] d);
        @(posedge clk_i);
        paddr <= a;
        pwr <= w;
        pwdata <= d;
        psel <= 1'h1;
        @(posedge clk_i);
        pen <= 1'h1;
        do @(posedge clk_i); while (prdy !== 1'h1);
        rd = prdata;
        er = perr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic issue(int m, int t, logic w);
        ea[m] = {base[t], 24'($urandom) & 24'hfffffc};
        et[m] = t;
        ew[m] = w;
        ewd[m] = $urandom;
        addr[32*m+:32] <= ea[m];
        wdata[32*m+:32] <= ewd[m];
        we[m] <= w;
        req[m] <= 1'h1;
    endtask
    task automatic wait_done(logic [4:0] msk);
        int n;
        int t;
        logic [4:0] drop;
        n = 0;
        while (msk != 5'h0) begin
            // Look between edges, drop finished requests at the next edge
            @(negedge clk_i);
            n++;
            drop = 5'h0;
            for (int i = 0; i < 5; i++) begin
                if (msk[i] && done[i] === 1'h1) begin
                    t = et[i];
                    msk[i] = 1'h0;
                    drop[i] = 1'h1;
                    fin[i] = n;
                    chk("err", 32'(!ok(i, t)), 32'(err[i]));
                    if (ok(i, t)) begin
                        chk("taddr", ea[i], taddr[32*t+:32]);
                        chk("twe", 32'(ew[i]), 32'(twe[t]));
                        if (ew[i])
                            chk("wd", ewd[i], twdata[32*t+:32]);
                        else
                            chk("rd", ~ea[i], rdata[32*i+:32]);
                    end
                end
            end
            @(posedge clk_i);
            req <= req & ~drop;
        end
    endtask
    task automatic go2(int a, int ta, logic wa, int b, int tb, logic wb);
        @(posedge clk_i);
        issue(a, ta, wa);
        issue(b, tb, wb);
        wait_done(5'(1 << a) | 5'(1 << b));
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        {req, we, psel, pen, pwr, rst_b_i, slow, addr, wdata} = '0;
        {paddr, pwdata} = '0;
        void'($urandom(86206));
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'h1;
        apb(`CBSW_ADDR_BRIDGE_CTRL, 1'h0, 32'h0);
        chk("ctrl reset", 32'h1, rd & 32'h1);
        chk("bridge pin", 32'h1, 32'(brst));
        apb(32'h40000030, 1'h0, 32'h0);
        chk("unmapped", 32'h1, 32'(er));
        @(posedge clk_i);
        issue(4, 0, 1'h0);
        apb(`CBSW_ADDR_BRIDGE_CTRL, 1'h1, 32'h0);
        wait_done(5'h10);
        chk("held access", 32'h1, 32'(fin[4] >= 3));
        apb(`CBSW_ADDR_BRIDGE_CTRL, 1'h0, 32'h0);
        chk("ctrl clear", 32'h0, rd & 32'h1);
        go2(2, 2, 1'h0, 3, 2, 1'h0);
        chk("hi first", 32'h1, 32'(fin[2] < fin[3]));
        go2(3, 1, 1'h0, 1, 1, 1'h0);
        chk("fill last", 32'h1, 32'(fin[3] < fin[1]));
        go2(0, 4, 1'h0, 4, 4, 1'h0);
        chk("cpu first", 32'h1, 32'(fin[0] < fin[4]));
        go2(2, 3, 1'h1, 3, 2, 1'h0);
        chk("no stall", fin[2], fin[3]);
        for (int t = 0; t < 5; t++) go2(0, t, 1'h0, 1, t, 1'h1);
        slow <= 1'h1;
        repeat (80) begin
            m = $urandom_range(4);
            go2(m, $urandom_range(4), 1'($urandom), (m + 1 +
                $urandom_range(3)) % 5, $urandom_range(4), 1'($urandom));
        end
        apb(`CBSW_ADDR_BRIDGE_CTRL, 1'h1, 32'h1);
        @(posedge clk_i);
        #1;
        chk("bridge set", 32'h1, 32'(brst));
        summarize();
    end
endmodule
bind cbsw_crossbar cbsw_crossbar_props props (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .mst_req_i(mst_req_i), .mst_addr_i(mst_addr_i),
    .mst_done_o(mst_done_o), .mst_err_o(mst_err_o), .tgt_req_o(tgt_req_o),
    .tgt_addr_o(tgt_addr_o), .tgt_ack_i(tgt_ack_i), .paddr_i(paddr_i),
    .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .mem_bridge_reset_o(mem_bridge_reset_o));
